//--- core/css_pkg.sv
// Constants shared by the startup sequencer and its frame checker.
// Assumes a 32-bit APB register port with byte addresses in the low 8 bits.
`default_nettype none
package css_pkg;

  localparam int          CSS_ADDR_W      = 8;
  localparam int          CSS_DATA_W      = 32;

  localparam logic [7:0]  CSS_CFG0_ADDR   = 8'h00;
  localparam logic [7:0]  CSS_CFG1_ADDR   = 8'h04;
  localparam logic [7:0]  CSS_STAT_ADDR   = 8'h08;
  localparam logic [7:0]  CSS_MASK_ADDR   = 8'h0C;
  localparam logic [7:0]  CSS_STATE_ADDR  = 8'h10;

  // Startup-setup word field positions (3-bit phase codes and the 1-bit done pipe flag)
  localparam int          CSS_DONE_LSB    = 0;
  localparam int          CSS_PIPE_BIT    = 3;
  localparam int          CSS_TS_LSB      = 4;
  localparam int          CSS_WE_LSB      = 8;
  localparam int          CSS_LOCK_LSB    = 12;
  localparam int          CSS_MATCH_LSB   = 16;
  localparam logic [31:0] CSS_CFG0_RST    = 32'h0007_7654;

  // Integrity and access word field positions
  localparam int          CSS_PFC_BIT     = 0;
  localparam int          CSS_LOCKOUT_LSB = 1;
  localparam int          CSS_LIVE_BIT    = 3;
  localparam int          CSS_PORT_LSB    = 4;
  localparam int          CSS_MON_LSB     = 6;
  localparam int          CSS_PWR_BIT     = 8;
  localparam logic [31:0] CSS_CFG1_RST    = 32'h0000_0000;

  // Phase codes: 0 means "with done" for tristate and write enable
  localparam logic [2:0]  CSS_PH_DONE     = 3'h0;
  localparam logic [2:0]  CSS_PH_KEEP     = 3'h7;
  localparam logic [2:0]  CSS_PH_NOSTALL  = 3'h7;
  localparam logic [2:0]  CSS_PH_LAST     = 3'h7;

  localparam logic [1:0]  CSS_PORT_AUTO   = 2'h0;
  localparam logic [1:0]  CSS_PORT_TOP    = 2'h1;
  localparam logic [1:0]  CSS_PORT_BOTTOM = 2'h2;
  localparam logic [1:0]  CSS_MON_FULL    = 2'h0;
  localparam logic [1:0]  CSS_MON_STATUS  = 2'h1;

  // Event bits of the status and mask registers
  localparam int          CSS_EV_DONE     = 0;
  localparam int          CSS_EV_CHECK    = 1;
  localparam int          CSS_EV_RB_REF   = 2;
  localparam int          CSS_EV_RC_REF   = 3;
  localparam int          CSS_EV_COUNT    = 4;

  localparam logic [31:0] CSS_CHECK_SEED  = 32'h0000_0000;

  typedef enum logic [1:0] {
    CSS_ST_IDLE = 2'b00,
    CSS_ST_RUN  = 2'b01,
    CSS_ST_END  = 2'b11
  } css_state_e;

endpackage
`default_nettype wire

//--- core/css_check_if.sv
// Carrier between the sequencer top and its per-frame checker.
// Assumes both ends run on the configuration clock.
`timescale 1ns/100ps
`default_nettype none
interface css_check_if;
  logic        enable;
  logic        valid;
  logic        is_check;
  logic [31:0] data;
  logic        commit;
  logic        error;

  modport src (output enable, output valid, output is_check, output data,
               input commit, input error);
  modport chk (input enable, input valid, input is_check, input data,
               output commit, output error);
endinterface
`default_nettype wire

//--- core/css_frame_check.sv
// Per-frame check of the configuration stream.
// Assumes stream words are synchronous to the configuration clock.
`timescale 1ns/100ps
`default_nettype none
module css_frame_check
  import css_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic reset_in,
  css_check_if.chk  link
);

  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic        commit_q;
  logic        error_q;
  logic        word_ok;
  wire         data_word  = link.valid && !link.is_check;
  wire         check_word = link.valid && link.is_check;

  // Rotate and fold each data word into the running frame value
  assign acc_d   = {acc_q[30:0], acc_q[31]} ^ link.data;
  assign word_ok = !link.enable || (link.data == acc_q);

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      acc_q <= CSS_CHECK_SEED;
    end else if (check_word) begin
      acc_q <= CSS_CHECK_SEED;
    end else if (data_word) begin
      acc_q <= acc_d;
    end
  end

  // A frame is released for loading at its check word if it matched or checking is disabled
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      commit_q <= 1'b0;
      error_q  <= 1'b0;
    end else begin
      commit_q <= check_word && word_ok;
      error_q  <= check_word && !word_ok;
    end
  end

  assign link.commit = commit_q;
  assign link.error  = error_q;

  sequence s_bad_check;
    link.valid && link.is_check && link.enable && (link.data != acc_q);
  endsequence

  AST_CHECK_FAIL: assert property (@(posedge clock_in) disable iff (reset_in)
    s_bad_check |=> link.error && !link.commit)
    else $error("mismatching check word did not raise the error");

  AST_CHECK_PASS: assert property (@(posedge clock_in) disable iff (reset_in)
    (link.valid && link.is_check && link.data == acc_q) |=> link.commit && !link.error)
    else $error("matching check word did not commit the frame");

endmodule
`default_nettype wire

//--- core/css_top.sv
// Startup sequencer and configuration-integrity controls with an APB port.
// Assumes clock_in is the configuration clock; lock and match inputs are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module css_top
  import css_pkg::*;
(
  input  wire logic                  clock_in,
  input  wire logic                  reset_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [CSS_ADDR_W-1:0] paddr_in,
  input  wire logic [CSS_DATA_W-1:0] pwdata_in,
  output logic      [CSS_DATA_W-1:0] prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  input  wire logic                  image_loaded_in,
  input  wire logic                  clock_lock_in,
  input  wire logic                  impedance_match_in,
  input  wire logic                  stream_valid_in,
  input  wire logic [31:0]           stream_data_in,
  input  wire logic                  stream_is_check_in,
  input  wire logic                  readback_request_in,
  input  wire logic                  reconfig_request_in,
  output logic                       readback_grant_out,
  output logic                       frame_commit_out,
  output logic                       done_out,
  output logic                       global_io_tristate_out,
  output logic                       global_write_enable_out,
  output logic                       bram_enable_out,
  output logic                       global_interconnect_hold_out,
  output logic                       global_set_reset_out,
  output logic                       init_status_n_out,
  output logic                       partial_load_error_out,
  output logic                       access_port_top_out,
  output logic                       access_port_bottom_out,
  output logic                       monitor_jtag_full_out,
  output logic                       monitor_jtag_status_out,
  output logic                       monitor_power_off_out,
  output logic                       irq_out
);

  css_state_e              st_q;
  css_state_e              st_d;
  logic [2:0]              phase_q;
  logic [31:0]             cfg0_q;
  logic [31:0]             cfg1_q;
  logic [CSS_EV_COUNT-1:0] stat_q;
  logic [CSS_EV_COUNT-1:0] mask_q;
  logic [CSS_EV_COUNT-1:0] events;
  logic [1:0]              sync_a_q;
  logic [1:0]              sync_b_q;
  logic                    done_raw_q;
  logic                    done_q;
  logic                    ts_rel_q;
  logic                    we_on_q;
  logic                    err_q;
  logic [31:0]             rdata_q;
  logic                    rerr_q;
  logic [31:0]             rdata_mux;

  css_check_if chk_link ();

  // Setting fields
  wire [2:0] done_sel  = cfg0_q[CSS_DONE_LSB +: 3];
  wire       done_pipe = cfg0_q[CSS_PIPE_BIT];
  wire [2:0] ts_sel    = cfg0_q[CSS_TS_LSB +: 3];
  wire [2:0] we_sel    = cfg0_q[CSS_WE_LSB +: 3];
  wire [2:0] lock_sel  = cfg0_q[CSS_LOCK_LSB +: 3];
  wire [2:0] match_sel = cfg0_q[CSS_MATCH_LSB +: 3];
  wire       pfc_en    = cfg1_q[CSS_PFC_BIT];
  wire [1:0] lockout   = cfg1_q[CSS_LOCKOUT_LSB +: 2];
  wire       live_mode = cfg1_q[CSS_LIVE_BIT];
  wire [1:0] port_sel  = cfg1_q[CSS_PORT_LSB +: 2];
  wire [1:0] mon_sel   = cfg1_q[CSS_MON_LSB +: 2];

  // Synchronised lock and match levels
  wire lock_ok  = sync_b_q[1];
  wire match_ok = sync_b_q[0];

  // APB decode
  wire setup    = psel_in && !penable_in;
  wire wr_acc   = psel_in && penable_in && pwrite_in;
  wire hit_cfg0 = (paddr_in == CSS_CFG0_ADDR);
  wire hit_cfg1 = (paddr_in == CSS_CFG1_ADDR);
  wire hit_stat = (paddr_in == CSS_STAT_ADDR);
  wire hit_mask = (paddr_in == CSS_MASK_ADDR);
  wire hit_st   = (paddr_in == CSS_STATE_ADDR);
  wire mapped   = hit_cfg0 || hit_cfg1 || hit_stat || hit_mask || hit_st;
  wire [CSS_EV_COUNT-1:0] w1c = (wr_acc && hit_stat) ? pwdata_in[CSS_EV_COUNT-1:0]
                                                     : {CSS_EV_COUNT{1'b0}};

  // Sequencer decode
  wire running     = (st_q == CSS_ST_RUN);
  wire stall_lock  = (lock_sel != CSS_PH_NOSTALL) && (phase_q == lock_sel) && !lock_ok;
  wire stall_match = (match_sel != CSS_PH_NOSTALL) && (phase_q == match_sel) && !match_ok;
  wire stall       = stall_lock || stall_match;
  wire advance     = running && !stall;
  wire done_live   = (done_sel != CSS_PH_KEEP) && (done_sel != CSS_PH_DONE);
  wire done_hit    = running && done_live && (phase_q == done_sel);
  wire ts_hit      = running && (ts_sel != CSS_PH_KEEP)
                     && ((ts_sel == CSS_PH_DONE) ? done_q : (phase_q == ts_sel));
  wire we_hit      = running && (we_sel != CSS_PH_KEEP)
                     && ((we_sel == CSS_PH_DONE) ? done_q : (phase_q == we_sel));
  wire rb_allowed  = (lockout == 2'h0);
  wire rc_allowed  = !lockout[1];
  wire rc_take     = reconfig_request_in && (st_q == CSS_ST_END) && rc_allowed;
  wire start_take  = (st_q == CSS_ST_IDLE) && image_loaded_in;
  wire done_next   = done_q || (done_pipe ? done_raw_q : done_hit);

  assign events[CSS_EV_DONE]   = done_next && !done_q;
  assign events[CSS_EV_CHECK]  = chk_link.error;
  assign events[CSS_EV_RB_REF] = readback_request_in && !rb_allowed;
  assign events[CSS_EV_RC_REF] = reconfig_request_in && !rc_allowed;

  // Read mux
  assign rdata_mux = hit_cfg0 ? cfg0_q :
                     hit_cfg1 ? cfg1_q :
                     hit_stat ? {28'h0000000, stat_q} :
                     hit_mask ? {28'h0000000, mask_q} :
                     hit_st   ? {20'h00000, err_q, we_on_q, ts_rel_q, done_q,
                                 lock_ok, match_ok, st_q, phase_q, 1'b0} :
                                32'h0000_0000;

  always_comb begin
    st_d = st_q;
    case (st_q)
      CSS_ST_IDLE: begin
        if (start_take) begin
          st_d = CSS_ST_RUN;
        end
      end
      CSS_ST_RUN: begin
        if (advance && phase_q == CSS_PH_LAST) begin
          st_d = CSS_ST_END;
        end
      end
      CSS_ST_END: begin
        if (rc_take) begin
          st_d = CSS_ST_IDLE;
        end
      end
      default: begin
        st_d = CSS_ST_IDLE;
      end
    endcase
  end

  // Two-flop synchronisers for the clock-manager lock and the match level
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      sync_a_q <= 2'h0;
      sync_b_q <= 2'h0;
    end else begin
      sync_a_q <= {clock_lock_in, impedance_match_in};
      sync_b_q <= sync_a_q;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      st_q    <= CSS_ST_IDLE;
      phase_q <= 3'h0;
    end else begin
      st_q <= st_d;
      if (start_take) begin
        phase_q <= 3'h0;
      end else if (advance && phase_q != CSS_PH_LAST) begin
        phase_q <= phase_q + 3'h1;
      end
    end
  end

  // Startup milestones, cleared when a new image starts
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      done_raw_q <= 1'b0;
      done_q     <= 1'b0;
      ts_rel_q   <= 1'b0;
      we_on_q    <= 1'b0;
    end else if (start_take) begin
      done_raw_q <= 1'b0;
      done_q     <= 1'b0;
      ts_rel_q   <= 1'b0;
      we_on_q    <= 1'b0;
    end else begin
      done_raw_q <= done_raw_q || done_hit;
      done_q     <= done_next;
      ts_rel_q   <= ts_rel_q || ts_hit;
      we_on_q    <= we_on_q || we_hit;
    end
  end

  // Check error stays until the next image starts
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      err_q <= 1'b0;
    end else if (chk_link.error) begin
      err_q <= 1'b1;
    end else if (start_take) begin
      err_q <= 1'b0;
    end
  end

  // Register writes; a new event wins over a clear in the same cycle
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cfg0_q <= CSS_CFG0_RST;
      cfg1_q <= CSS_CFG1_RST;
      mask_q <= {CSS_EV_COUNT{1'b0}};
      stat_q <= {CSS_EV_COUNT{1'b0}};
    end else begin
      if (wr_acc && hit_cfg0) begin
        cfg0_q <= pwdata_in & 32'h0007_777F;
      end
      if (wr_acc && hit_cfg1) begin
        cfg1_q <= pwdata_in & 32'h0000_01FF;
      end
      if (wr_acc && hit_mask) begin
        mask_q <= pwdata_in[CSS_EV_COUNT-1:0];
      end
      stat_q <= (stat_q & ~w1c) | events;
    end
  end

  // Read data and error are taken in the setup cycle
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= 32'h0000_0000;
      rerr_q  <= 1'b0;
    end else if (setup) begin
      rdata_q <= pwrite_in ? 32'h0000_0000 : rdata_mux;
      rerr_q  <= !mapped;
    end
  end

  assign chk_link.enable   = pfc_en;
  assign chk_link.valid    = stream_valid_in;
  assign chk_link.is_check = stream_is_check_in;
  assign chk_link.data     = stream_data_in;

  css_frame_check u_check (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .link     (chk_link)
  );

  assign prdata_out                   = rdata_q;
  assign pready_out                   = 1'b1;
  assign pslverr_out                  = rerr_q;
  assign frame_commit_out             = chk_link.commit;
  assign readback_grant_out           = readback_request_in && rb_allowed;
  assign done_out                     = done_q;
  assign global_io_tristate_out       = !ts_rel_q;
  assign global_write_enable_out      = we_on_q;
  assign bram_enable_out              = we_on_q;
  assign global_interconnect_hold_out = !live_mode && !done_q;
  assign global_set_reset_out         = !live_mode && (st_q != CSS_ST_END);
  assign init_status_n_out            = !err_q;
  assign partial_load_error_out       = err_q;
  assign access_port_top_out          = (port_sel != CSS_PORT_BOTTOM);
  assign access_port_bottom_out       = (port_sel == CSS_PORT_BOTTOM);
  assign monitor_jtag_full_out        = (mon_sel == CSS_MON_FULL);
  assign monitor_jtag_status_out      = (mon_sel == CSS_MON_FULL)
                                        || (mon_sel == CSS_MON_STATUS);
  assign monitor_power_off_out        = cfg1_q[CSS_PWR_BIT];
  assign irq_out                      = |(stat_q & mask_q);

  sequence s_done_phase;
    done_hit && !done_pipe && !done_q;
  endsequence

  sequence s_pipe_phase;
    done_hit && done_pipe && !done_raw_q;
  endsequence

  AST_DONE_IN_PHASE: assert property (@(posedge clock_in) disable iff (reset_in)
    s_done_phase |=> done_out)
    else $error("done did not rise in its phase");

  AST_DONE_PIPE: assert property (@(posedge clock_in) disable iff (reset_in)
    s_pipe_phase |=> !done_out ##1 done_out)
    else $error("piped done was not one cycle late");

  AST_TS_RELEASE: assert property (@(posedge clock_in) disable iff (reset_in)
    $fell(global_io_tristate_out) |-> $past(running) && ($past(ts_sel) != CSS_PH_KEEP))
    else $error("tristate released outside its phase");

  AST_WE_PHASE: assert property (@(posedge clock_in) disable iff (reset_in)
    (running && we_sel != CSS_PH_KEEP && we_sel != CSS_PH_DONE && phase_q == we_sel)
    |=> global_write_enable_out)
    else $error("write enable missed its phase");

  AST_BRAM_WITH_WE: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(bram_enable_out) |-> $rose(global_write_enable_out))
    else $error("block RAM enabled apart from write enable");

  AST_LOCK_STALL: assert property (@(posedge clock_in) disable iff (reset_in)
    (running && stall_lock) |=> (phase_q == $past(phase_q)) && running)
    else $error("sequence moved while waiting for lock");

  AST_MATCH_STALL: assert property (@(posedge clock_in) disable iff (reset_in)
    (running && stall_match) |=> (phase_q == $past(phase_q)))
    else $error("sequence moved while waiting for match");

  AST_ADVANCE: assert property (@(posedge clock_in) disable iff (reset_in)
    (advance && phase_q != CSS_PH_LAST && !start_take) |=> (phase_q == $past(phase_q) + 3'h1))
    else $error("sequence did not step by one phase");

  AST_RC_LOCKOUT: assert property (@(posedge clock_in) disable iff (reset_in)
    (st_q == CSS_ST_END && reconfig_request_in && lockout[1]) |=> (st_q == CSS_ST_END))
    else $error("reconfiguration taken under lockout");

  AST_LIVE_HOLD: assert property (@(posedge clock_in) disable iff (reset_in)
    live_mode |-> !global_set_reset_out && !global_interconnect_hold_out)
    else $error("global resets asserted in live mode");

  AST_ERR_FLAG: assert property (@(posedge clock_in) disable iff (reset_in)
    chk_link.error |=> !init_status_n_out && partial_load_error_out)
    else $error("check error not shown on status outputs");

endmodule
`default_nettype wire

//--- test/css_cfg_source.sv
// Model of the configuration source: image-loaded strobe and stream words.
// Assumes the sequencer samples all of these on the rising edge of clock_in.
`timescale 1ns/100ps
`default_nettype none
module css_cfg_source (
  input  wire logic        clock_in,
  output logic             image_loaded_out,
  output logic             valid_out,
  output logic [31:0]      data_out,
  output logic             is_check_out
);
  initial begin
    image_loaded_out = 1'b0;
    valid_out = 1'b0;
    data_out = 32'hA5A5_A5A5;
    is_check_out = 1'b0;
  end

  task automatic start_image();
    image_loaded_out <= 1'b1;
    @(posedge clock_in);
    image_loaded_out <= 1'b0;
  endtask

  // Two data words then the check word; bad spoils the check word
  task automatic send_frame(input logic [31:0] d0, input logic [31:0] d1, input logic bad);
    @(posedge clock_in);
    valid_out <= 1'b1;
    data_out <= d0;
    @(posedge clock_in);
    data_out <= d1;
    @(posedge clock_in);
    data_out <= {d0[30:0], d0[31]} ^ d1 ^ {31'h0, bad};
    is_check_out <= 1'b1;
    @(posedge clock_in);
    valid_out <= 1'b0;
    is_check_out <= 1'b0;
    data_out <= ~data_out;
  endtask
endmodule
`default_nettype wire

//--- test/css_top_tb.sv
// Self-checking bench for the startup sequencer over APB.
// Assumes css_cfg_source as the configuration source model.
`timescale 1ns/100ps
`default_nettype none
module css_top_tb
  import css_pkg::*;
;
  logic        clk, rst, psel, pen, pwr, rb_req, rc_req, lock, match, err, loaded, sv, sc;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, sd;
  logic        pready, pslverr, grant, commit, done, tri_o, global_write_enable, bram, hold, global_set_reset;
  logic        init_n, perr, top, bot, jfull, jstat, poff, irq;
  int          n_fail = 0;
  int          comparisons = 0;

  css_top u_dut (
    .clock_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .image_loaded_in(loaded), .clock_lock_in(lock),
    .impedance_match_in(match), .stream_valid_in(sv), .stream_data_in(sd),
    .stream_is_check_in(sc), .readback_request_in(rb_req), .reconfig_request_in(rc_req),
    .readback_grant_out(grant), .frame_commit_out(commit), .done_out(done),
    .global_io_tristate_out(tri_o), .global_write_enable_out(global_write_enable), .bram_enable_out(bram),
    .global_interconnect_hold_out(hold), .global_set_reset_out(global_set_reset),
    .init_status_n_out(init_n), .partial_load_error_out(perr),
    .access_port_top_out(top), .access_port_bottom_out(bot),
    .monitor_jtag_full_out(jfull), .monitor_jtag_status_out(jstat),
    .monitor_power_off_out(poff), .irq_out(irq));

  css_cfg_source u_src (.clock_in(clk), .image_loaded_out(loaded), .valid_out(sv),
                        .data_out(sd), .is_check_out(sc));

  // Clock runs free, so startup is never starved before done
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Leaves END, starts an image and notes when each milestone appears
  task automatic startup(input logic [31:0] c0, input logic [31:0] c1,
                         input int ed, input int et, input int ew);
    int fd, ft, fw;
    apb(1'b1, CSS_CFG0_ADDR, c0);
    apb(1'b1, CSS_CFG1_ADDR, c1);
    rc_req <= 1'b1;
    @(posedge clk);
    rc_req <= 1'b0;
    u_src.start_image();
    fd = 0;
    ft = 0;
    fw = 0;
    for (int n = 1; n <= 12; n++) begin
      @(posedge clk);
      #1;
      if (n == 1) chk1(global_set_reset | hold, !c1[CSS_LIVE_BIT]);
      if (done === 1'b1 && fd == 0) fd = n;
      if (tri_o === 1'b0 && ft == 0) ft = n;
      if (global_write_enable === 1'b1 && fw == 0) fw = n;
      chk1(bram, global_write_enable);
    end
    chk(fd, ed);
    chk(ft, et);
    chk(fw, ew);
    chk1(global_set_reset, 1'b0);
    chk1(hold, ed == 0 && !c1[CSS_LIVE_BIT]);
  endtask

  task automatic stall(input logic [31:0] c0, input logic [2:0] ph);
    int k;
    @(posedge clk);
    lock <= 1'b0;
    match <= 1'b0;
    startup_hold(c0);
    repeat (15) @(posedge clk);
    apb(1'b0, CSS_STATE_ADDR, 32'h0);
    chk(32'(rd[5:1]), 32'({2'b01, ph}));
    chk1(done, 1'b0);
    lock <= 1'b1;
    match <= 1'b1;
    for (k = 0; k < 20 && done !== 1'b1; k++) @(posedge clk);
    #1;
    chk1(done, 1'b1);
  endtask

  task automatic startup_hold(input logic [31:0] c0);
    apb(1'b1, CSS_CFG0_ADDR, c0);
    rc_req <= 1'b1;
    @(posedge clk);
    rc_req <= 1'b0;
    u_src.start_image();
  endtask

  task automatic frames();
    apb(1'b1, CSS_MASK_ADDR, 32'h2);
    apb(1'b1, CSS_CFG1_ADDR, 32'h1);
    u_src.send_frame(32'h1234_5678, 32'h0F0F_0F0F, 1'b0);
    #1;
    chk1(commit, 1'b1);
    u_src.send_frame(32'h8000_0001, 32'hC3C3_0000, 1'b1);
    #1;
    chk1(commit, 1'b0);
    @(posedge clk);
    #1;
    chk({init_n, perr, irq}, {1'b0, 1'b1, 1'b1});
    apb(1'b1, CSS_STAT_ADDR, 32'h2);
    #1;
    chk1(irq, 1'b0);
    apb(1'b1, CSS_MASK_ADDR, 32'h1);
    #1;
    chk1(irq, 1'b1);
    apb(1'b1, CSS_STAT_ADDR, 32'hF);
    #1;
    chk1(irq, 1'b0);
    apb(1'b1, CSS_CFG1_ADDR, 32'h0);
    u_src.send_frame(32'h0000_0011, 32'h0000_0022, 1'b1);
    #1;
    chk1(commit, 1'b1);
  endtask

  task automatic lockout();
    @(posedge clk);
    rb_req <= 1'b1;
    #1;
    chk1(grant, 1'b1);
    apb(1'b1, CSS_CFG1_ADDR, 32'h2);
    #1;
    chk1(grant, 1'b0);
    apb(1'b1, CSS_CFG1_ADDR, 32'h4);
    rb_req <= 1'b0;
    rc_req <= 1'b1;
    @(posedge clk);
    rc_req <= 1'b0;
    apb(1'b0, CSS_STAT_ADDR, 32'h0);
    chk(32'(rd[3:2]), 32'h3);
    apb(1'b0, CSS_STATE_ADDR, 32'h0);
    chk(32'(rd[5:4]), 32'h3);
  endtask

  task automatic end_of_test();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_fail++;
    end_of_test();
  end

  initial begin
    {rst, psel, pen, pwr, rb_req, rc_req, lock, match} = 8'b1000_0011;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rchk(CSS_CFG0_ADDR, CSS_CFG0_RST);
    rchk(CSS_CFG1_ADDR, 32'h0);
    rchk(8'h20, 32'h0);
    chk1(err, 1'b1);
    apb(1'b1, CSS_STATE_ADDR, 32'hFFFF_FFFF);
    rchk(CSS_STATE_ADDR, 32'h0000_00C0);
    chk({tri_o, global_set_reset, init_n, irq}, 32'hE);
    startup(CSS_CFG0_RST, 32'h0, 5, 6, 7);
    startup(32'h0007_7309, 32'h8, 3, 4, 4);
    startup(32'h0007_7727, 32'h0, 0, 3, 0);
    startup(32'h0007_7532, 32'h0, 3, 4, 6);
    startup(32'h0007_7165, 32'h0, 6, 7, 2);
    startup(32'h0007_7213, 32'h0, 4, 2, 3);
    startup(32'h0007_7546, 32'h0, 7, 5, 6);
    stall(32'h0007_2654, 3'h2);
    stall(32'h0007_0654, 3'h0);
    stall(32'h0003_7654, 3'h3);
    frames();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CSS_CFG1_ADDR, 32'((i << 4) | (i << 6) | ((i & 1) << 8)));
      #1;
      chk({top, bot}, {i != 2, i == 2});
      chk({jfull, jstat}, {i == 0, i <= 1});
      chk1(poff, i[0]);
    end
    lockout();
    end_of_test();
  end
endmodule
`default_nettype wire
